/* File: crap_controller.sv */
// Purpose: Controller end; APB slave issuing register requests.
// Assumes: Terminal on the same clock.
// Notes:   CMD write starts a request; STATUS bit 1 shows done.
`timescale 1ns/10ps
module crap_controller (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // Process image
  crap_if.ctrl             link
);
  logic [7:0]  cmd_reg;
  logic [15:0] wdata_reg;
  logic [15:0] pdata_reg;
  logic [15:0] rdata_reg;
  logic        busy_reg;
  logic        done_reg;
  logic [31:0] prdata_reg;
  logic        pslverr_reg;
  logic [7:0]  expect_ack;
  logic        wr_acc;
  logic        acked;

  assign wr_acc     = i_psel && i_penable && i_pwrite;
  assign expect_ack = cmd_reg[crap_pkg::CTRL_WR_BIT] ? (cmd_reg & 8'hBF) : cmd_reg;
  assign acked      = busy_reg && link.status_byte == expect_ack;

  // Request held steady until acknowledged; value sent whole as one 16-bit word.
  assign link.ctrl_byte        = busy_reg ? cmd_reg : 8'h00;
  assign link.output_data_word = busy_reg ? wdata_reg : pdata_reg;
  assign o_pready              = 1'b1;
  assign o_prdata              = prdata_reg;
  assign o_pslverr             = pslverr_reg;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cmd_reg   <= 8'h00;
      wdata_reg <= 16'h0000;
      pdata_reg <= 16'h0000;
      busy_reg  <= 1'b0;
      done_reg  <= 1'b0;
      rdata_reg <= 16'h0000;
    end else begin
      if (wr_acc && i_paddr == crap_pkg::APB_PDATA) begin
        pdata_reg <= i_pwdata[15:0];
      end
      if (wr_acc && i_paddr == crap_pkg::APB_WDATA && !busy_reg) begin
        wdata_reg <= i_pwdata[15:0];
      end
      if (acked) begin
        busy_reg <= 1'b0;
        done_reg <= 1'b1;
        if (!cmd_reg[crap_pkg::CTRL_WR_BIT]) begin
          rdata_reg <= link.input_data_word;
        end
      end else if (wr_acc && i_paddr == crap_pkg::APB_CMD && !busy_reg) begin
        cmd_reg  <= {1'b1, i_pwdata[6:0]};
        busy_reg <= 1'b1;
        done_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (i_psel && !i_penable) begin
      pslverr_reg <= 1'b0;
      case (i_paddr)
        crap_pkg::APB_CMD:    prdata_reg <= {24'h000000, cmd_reg};
        crap_pkg::APB_WDATA:  prdata_reg <= {16'h0000, wdata_reg};
        crap_pkg::APB_STATUS: prdata_reg <= {30'h0, done_reg, busy_reg};
        crap_pkg::APB_RDATA:  prdata_reg <= {16'h0000, rdata_reg};
        crap_pkg::APB_PDATA:  prdata_reg <= {16'h0000, pdata_reg};
        default: begin
          prdata_reg  <= 32'h0000_0000;
          pslverr_reg <= 1'b1;
        end
      endcase
    end
  end
endmodule : crap_controller

/* File: crap_if.sv */
// Purpose: Cyclic process image between controller and terminal.
// Assumes: Both ends run on the same clock.
// Notes:   Control byte plus word out, status byte plus word in.
`timescale 1ns/10ps
interface crap_if;
  logic [7:0]  ctrl_byte;
  logic [15:0] output_data_word;
  logic [7:0]  status_byte;
  logic [15:0] input_data_word;
  modport term (input ctrl_byte, input output_data_word,
                output status_byte, output input_data_word);
  modport ctrl (output ctrl_byte, output output_data_word,
                input status_byte, input input_data_word);
endinterface : crap_if

/* File: crap_pkg.sv */
// Purpose: Shared constants for the cyclic register access port.
// Assumes: One 100 MHz clock, asynchronous active-low reset.
// Notes:   Control byte fields, register numbers and code word.
package crap_pkg;
  localparam int           CTRL_REG_BIT    = 7;
  localparam int           CTRL_WR_BIT     = 6;
  localparam int           ADDR_W          = 6;
  localparam int           NUM_REGS        = 64;
  localparam logic [5:0]   REG_FW_VERSION  = 6'h09;
  localparam logic [5:0]   REG_UNLOCK_CODE = 6'h1F;
  localparam logic [5:0]   REG_FEATURE     = 6'h20;
  localparam logic [15:0]  UNLOCK_WORD     = 16'h1235;
  localparam logic [15:0]  UNLOCK_RESET    = 16'h0000;
  localparam logic [15:0]  FEATURE_RESET   = 16'h0000;
  localparam logic [15:0]  USER_RESET      = 16'h0000;
  localparam logic [7:0]   STATUS_RESET    = 8'h00;
  // APB map of the controller's own registers.
  localparam logic [11:0]  APB_CMD         = 12'h000;
  localparam logic [11:0]  APB_WDATA       = 12'h004;
  localparam logic [11:0]  APB_STATUS      = 12'h008;
  localparam logic [11:0]  APB_RDATA       = 12'h00C;
  localparam logic [11:0]  APB_PDATA       = 12'h010;
  localparam int           ST_BUSY_BIT     = 0;
  localparam int           ST_DONE_BIT     = 1;
endpackage : crap_pkg

/* File: crap_properties.sv */
// Purpose: Checker for the process image between both ends.
// Assumes: One clock, asynchronous active-low reset.
// Notes:   Reference copies of the code word and feature word.
`timescale 1ns/10ps
module crap_properties #(
  parameter logic [15:0] FW_VERSION = 16'h3132
) (
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic [7:0]  ctrl_byte,
  input wire logic [15:0] output_data_word,
  input wire logic [7:0]  status_byte,
  input wire logic [15:0] input_data_word
);
  logic [15:0] code_q;
  logic [15:0] feat_q;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  ////////////////////////////////////////
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      code_q <= crap_pkg::UNLOCK_RESET;
    end else if (ctrl_byte == {2'b11, crap_pkg::REG_UNLOCK_CODE}) begin
      code_q <= output_data_word;
    end
  end
  // Locked writes must not reach the reference copy either.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      feat_q <= crap_pkg::FEATURE_RESET;
    end else if (ctrl_byte == {2'b11, crap_pkg::REG_FEATURE} &&
                 code_q == crap_pkg::UNLOCK_WORD) begin
      feat_q <= output_data_word;
    end
  end
  sequence s_rd;
    ctrl_byte[7] && !ctrl_byte[6];
  endsequence
  sequence s_wr;
    ctrl_byte[7] && ctrl_byte[6];
  endsequence
  // The controller drops its request on the acknowledge, so one held cycle is all that is seen.
  sequence s_held;
    ctrl_byte[7] && $stable(ctrl_byte);
  endsequence
  chk_read_echo: assert property (s_rd |=> status_byte == $past(ctrl_byte))
    else $error("read acknowledge differs from control byte");
  chk_write_ack: assert property (s_wr |=> status_byte == ($past(ctrl_byte) & 8'hBF))
    else $error("write acknowledge wrong");
  chk_fw_value: assert property (ctrl_byte == {2'b10, crap_pkg::REG_FW_VERSION}
    |=> input_data_word == FW_VERSION)
    else $error("firmware version wrong");
  chk_code_read: assert property (ctrl_byte == {2'b10, crap_pkg::REG_UNLOCK_CODE}
    |=> input_data_word == code_q)
    else $error("code word readback wrong");
  chk_feature_read: assert property (ctrl_byte == {2'b10, crap_pkg::REG_FEATURE}
    |=> input_data_word == feat_q)
    else $error("feature readback wrong");
  chk_write_data: assert property (s_wr |=> input_data_word == 16'h0000)
    else $error("write answer word not zero");
  chk_ack_stands: assert property (s_held |=> $stable(status_byte) && $stable(input_data_word))
    else $error("answer moved while request held");
  chk_ack_bounded: assert property ($rose(ctrl_byte[7]) |-> ##[1:2] status_byte[7])
    else $error("register request not answered");
endmodule : crap_properties

/* File: crap_terminal.sv */
// Purpose: Terminal end of the register access path.
// Assumes: Request fields arrive from logic on the same clock.
// Notes:   Each request is served once, then answered until it changes.
`timescale 1ns/10ps
module crap_terminal #(
  parameter logic [15:0] FW_VERSION = 16'h3132 // Arbitrary version characters.
) (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // Process image
  crap_if.term             link,
  // Process data and active configuration
  output logic [15:0]      o_process_out,
  output logic [15:0]      o_active_feature,
  output logic             o_unlocked
);
  logic [15:0] regs_reg [crap_pkg::NUM_REGS];
  logic [7:0]  last_ctrl_reg;
  logic        served_reg;
  logic [7:0]  status_reg;
  logic [15:0] in_word_reg;
  logic        unlocked_reg;
  logic [15:0] active_feature_reg;
  logic        boot_reg;
  logic        req;
  logic        wr;
  logic [5:0]  addr;
  logic        wr_ok;

  assign req   = link.ctrl_byte[crap_pkg::CTRL_REG_BIT];
  assign wr    = link.ctrl_byte[crap_pkg::CTRL_WR_BIT];
  assign addr  = link.ctrl_byte[crap_pkg::ADDR_W-1:0];
  assign wr_ok = unlocked_reg || (addr == crap_pkg::REG_UNLOCK_CODE);

  assign link.status_byte     = status_reg;
  assign link.input_data_word = in_word_reg;

  ////////////////////////////////////////////////////////////////////////////
  // A new request is recognised by a change of control byte.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      last_ctrl_reg <= 8'h00;
      served_reg    <= 1'b0;
    end else begin
      last_ctrl_reg <= link.ctrl_byte;
      served_reg    <= req && (served_reg ? last_ctrl_reg == link.ctrl_byte : 1'b1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register array; only writes change it, reads never do.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < crap_pkg::NUM_REGS; i++) begin
        regs_reg[i] <= crap_pkg::USER_RESET;
      end
    end else if (req && wr && wr_ok && !(served_reg && last_ctrl_reg == link.ctrl_byte)) begin
      regs_reg[addr] <= link.output_data_word;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      unlocked_reg <= 1'b0;
    end else if (req && wr && addr == crap_pkg::REG_UNLOCK_CODE) begin
      unlocked_reg <= (link.output_data_word == crap_pkg::UNLOCK_WORD);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Answer path.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      status_reg  <= crap_pkg::STATUS_RESET;
      in_word_reg <= 16'h0000;
    end else if (!req) begin
      status_reg  <= crap_pkg::STATUS_RESET;
      in_word_reg <= 16'h0000;
    end else if (wr) begin
      status_reg  <= link.ctrl_byte & 8'hBF;
      in_word_reg <= 16'h0000;
    end else begin
      status_reg  <= link.ctrl_byte;
      if (addr == crap_pkg::REG_FW_VERSION) begin
        in_word_reg <= FW_VERSION;
      end else begin
        in_word_reg <= regs_reg[addr];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Process data passes through only outside register mode.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_process_out <= 16'h0000;
    end else if (!req) begin
      o_process_out <= link.output_data_word;
    end
  end

  // Configuration takes effect only once, after reset is released.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      boot_reg           <= 1'b1;
      active_feature_reg <= crap_pkg::FEATURE_RESET;
    end else if (boot_reg) begin
      boot_reg           <= 1'b0;
      active_feature_reg <= regs_reg[crap_pkg::REG_FEATURE];
    end
  end

  assign o_active_feature = active_feature_reg;
  assign o_unlocked       = unlocked_reg;
endmodule : crap_terminal

/* File: tb_cyclic_register_access_port.sv */
// Purpose: Self-checking bench for both ends of the register path.
// Assumes: Controller reached over APB as a zero-wait slave.
// Notes:   Table of register operations, then the awkward cases.
`timescale 1ns/10ps
module tb_cyclic_register_access_port;
  localparam logic [15:0] FW = 16'h3132; // Arbitrary version characters.
  localparam logic [5:0]  RV = crap_pkg::REG_FW_VERSION;
  localparam logic [5:0]  RC = crap_pkg::REG_UNLOCK_CODE;
  localparam logic [5:0]  RF = crap_pkg::REG_FEATURE;
  // Row: write flag, register, data to send, word a read should return.
  localparam logic [38:0] ROWS [11] = '{
    {1'b0, RV, 16'h0000, FW},
    {1'b1, RF, 16'h0002, 16'h0000},
    {1'b0, RF, 16'h0000, 16'h0000},
    {1'b1, RC, 16'h1235, 16'h0000},
    {1'b0, RC, 16'h0000, 16'h1235},
    {1'b1, RF, 16'h0002, 16'h0000},
    {1'b0, RF, 16'h0000, 16'h0002},
    {1'b1, RC, 16'h0000, 16'h0000},
    {1'b1, RF, 16'h00FF, 16'h0000},
    {1'b0, RF, 16'h5555, 16'h0002},
    {1'b0, RC, 16'h0000, 16'h0000}};
  logic        i_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [15:0] proc_out;
  logic [15:0] act_feat;
  logic        unlocked;
  logic [31:0] rd_v;
  logic        err_v;
  int          n;
  int          err_total = 0;
  int          check_count = 0;
  always #5 i_clk = ~i_clk;
  crap_if link ();
  crap_terminal #(.FW_VERSION(FW)) u_crap_terminal (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .link(link), .o_process_out(proc_out), .o_active_feature(act_feat), .o_unlocked(unlocked));
  crap_controller u_crap_controller (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .link(link));
  crap_properties #(.FW_VERSION(FW)) u_crap_properties (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .ctrl_byte(link.ctrl_byte), .output_data_word(link.output_data_word),
    .status_byte(link.status_byte), .input_data_word(link.input_data_word));
  ////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // Entering on a fresh edge keeps the release and the next setup apart.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge i_clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge i_clk);
    penable <= 1'b1;
    do begin
      @(posedge i_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd_v  = prdata;
    err_v = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) begin
      check("pready", 32'h0, 32'h1);
      stop_test();
    end
  endtask : apb
  task automatic reg_op(input logic wr, input logic [5:0] a, input logic [15:0] d);
    int k;
    k = 0;
    apb(1'b1, crap_pkg::APB_WDATA, {16'h0000, d});
    apb(1'b1, crap_pkg::APB_CMD, {24'h000000, 1'b1, wr, a});
    do begin
      apb(1'b0, crap_pkg::APB_STATUS, 32'h0);
      k++;
    end while ({rd_v[crap_pkg::ST_DONE_BIT], rd_v[crap_pkg::ST_BUSY_BIT]} !== 2'b10 && k < 40);
    if (k >= 40) begin
      check("done", 32'h0, 32'h1);
      stop_test();
    end
    apb(1'b0, crap_pkg::APB_RDATA, 32'h0);
  endtask : reg_op
  ////////////////////////////////////////
  initial begin
    repeat (6) @(posedge i_clk);
    i_rst_n <= 1'b1;
    foreach (ROWS[i]) begin
      reg_op(ROWS[i][38], ROWS[i][37:32], ROWS[i][31:16]);
      if (!ROWS[i][38]) check("rdata", rd_v, {16'h0000, ROWS[i][15:0]});
    end
    check("active", {16'h0000, act_feat}, 32'h0);
    check("relock", {31'h0, unlocked}, 32'h0);
    apb(1'b0, 12'h0FC, 32'h0);
    check("slverr", {31'h0, err_v}, 32'h1);
    apb(1'b1, crap_pkg::APB_PDATA, 32'h0000ABCD);
    n = 0;
    while (proc_out !== 16'hABCD && n < 20) begin
      @(posedge i_clk);
      n++;
    end
    check("process", {16'h0000, proc_out}, 32'h0000ABCD);
    apb(1'b0, crap_pkg::APB_PDATA, 32'h0);
    check("pdata", rd_v, 32'h0000ABCD);
    reg_op(1'b1, RC, crap_pkg::UNLOCK_WORD);
    check("unlock", {31'h0, unlocked}, 32'h1);
    apb(1'b0, crap_pkg::APB_WDATA, 32'h0);
    check("wdata", rd_v, {16'h0000, crap_pkg::UNLOCK_WORD});
    apb(1'b0, crap_pkg::APB_CMD, 32'h0);
    check("cmd", rd_v, {24'h000000, 2'b11, RC});
    i_rst_n <= 1'b0;
    repeat (6) @(posedge i_clk);
    check("rst_lock", {31'h0, unlocked}, 32'h0);
    i_rst_n <= 1'b1;
    reg_op(1'b0, RC, 16'h0000);
    check("rst_code", rd_v, 32'h0);
    stop_test();
  end
endmodule : tb_cyclic_register_access_port
